/* inc/adc_ovr_pkg.sv */
// Shared constants and carrier types for the converter overrange block
package adc_ovr_pkg;
    // ==================================================
    // Widths
    localparam int SAMPLE_W = 12;
    localparam int MAG_W = 11;
    localparam int CMP_W = 8;
    localparam int DATA_W = 16;
    localparam int TRIM_W = 16;
    localparam int SET_W = 3;
    localparam int STRETCH_W = 11;
    localparam int WIN_W = 8;
    localparam int ADDR_W = 8;
    localparam int IRQ_W = 4;
    // ==================================================
    // Magnitude and timing
    localparam logic [SAMPLE_W-1:0] MOST_NEG_CODE = 12'h800;
    localparam logic [MAG_W-1:0] MAG_SAT = 11'h7ff;
    localparam int STRETCH_BASE = 8;
    // ==================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_THRESH = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STRETCH = 8'h08;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] REG_FS_A = 8'h18;
    localparam logic [ADDR_W-1:0] REG_FS_B = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_OA0_A = 8'h20;
    localparam logic [ADDR_W-1:0] REG_OA0_B = 8'h24;
    localparam logic [ADDR_W-1:0] REG_OA90_A = 8'h28;
    localparam logic [ADDR_W-1:0] REG_OA90_B = 8'h2c;
    localparam logic [ADDR_W-1:0] REG_OB0_A = 8'h30;
    localparam logic [ADDR_W-1:0] REG_OB0_B = 8'h34;
    // ==================================================
    // Field positions
    localparam int CTRL_SINGLE = 0;
    localparam int CTRL_DECIM = 1;
    localparam int CTRL_FGCAL = 2;
    localparam int THR_HIGH_LSB = 0;
    localparam int THR_LOW_LSB = 8;
    // ==================================================
    // Reset values and AXI response codes
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [CMP_W-1:0] HIGH_THR_RST = 8'hff;
    localparam logic [CMP_W-1:0] LOW_THR_RST = 8'h40;
    localparam logic [SET_W-1:0] STRETCH_RST = 3'h0;
    localparam logic [TRIM_W-1:0] FS_TRIM_RST = 16'ha000;
    localparam logic [TRIM_W-1:0] OFS_TRIM_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==================================================
    // Carriers
    typedef struct packed {
        logic [SAMPLE_W-1:0] a;
        logic [SAMPLE_W-1:0] b;
    } sample_pair_t;
    typedef struct packed {
        logic low;
        logic high;
    } flag_pair_t;
    typedef struct packed {
        logic [DATA_W-1:0] i;
        logic [DATA_W-1:0] q;
    } iq_t;
    typedef struct packed {
        logic [TRIM_W-1:0] input_a;
        logic [TRIM_W-1:0] input_b;
    } trim_set_t;
endpackage

/* verilog/overrange_monitor.sv */
// Per-channel magnitude, threshold compare, pin stretch and embed window
module overrange_monitor
    import adc_ovr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] sample,
    input wire logic [CMP_W-1:0] high_thr,
    input wire logic [CMP_W-1:0] low_thr,
    input wire logic [SET_W-1:0] stretch_setting,
    output flag_pair_t pin_flag,
    output flag_pair_t embed_flag,
    output flag_pair_t hit
);
    logic [SAMPLE_W-1:0] neg;
    logic [MAG_W-1:0] mag;
    logic [CMP_W-1:0] mag_top;
    logic [1:0] next_hit;
    logic [STRETCH_W-1:0] stretch_last;
    logic [WIN_W-1:0] win_last;
    logic [1:0][STRETCH_W-1:0] hold_cnt;
    logic [1:0] pin_q;
    logic [1:0] hit_q;
    logic [1:0] acc;
    logic [1:0] last_win;
    logic [1:0] emb_q;
    logic [WIN_W-1:0] win_cnt;

    // ==================================================
    // Magnitude and compare
    always_comb
    begin
        neg = SAMPLE_W'(~sample) + SAMPLE_W'(1);
        // Samples are two's complement, sign in the top bit
        if (!sample[SAMPLE_W-1])
            mag = sample[MAG_W-1:0];
        else if (sample == MOST_NEG_CODE)
            mag = MAG_SAT;
        else
            mag = neg[MAG_W-1:0];
        mag_top = mag[MAG_W-1 -: CMP_W];
        next_hit[0] = sample_valid && (mag_top >= high_thr);
        next_hit[1] = sample_valid && (mag_top >= low_thr);
    end

    assign stretch_last = (STRETCH_W'(STRETCH_BASE) << stretch_setting) - STRETCH_W'(1);
    assign win_last = (WIN_W'(1) << stretch_setting) - WIN_W'(1);

    // ==================================================
    // Pin stretch: high for the full length after the latest hit
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            hold_cnt <= '0;
            pin_q <= '0;
            hit_q <= '0;
        end
        else
        begin
            hit_q <= next_hit;
            for (int k = 0; k < 2; k++)
            begin
                if (next_hit[k])
                begin
                    hold_cnt[k] <= stretch_last;
                    pin_q[k] <= 1'b1;
                end
                else if (hold_cnt[k] != '0)
                    hold_cnt[k] <= hold_cnt[k] - STRETCH_W'(1);
                else
                    pin_q[k] <= 1'b0;
            end
        end
    end

    // ==================================================
    // Embed window of 2^N samples; bit covers current and last period
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            win_cnt <= '0;
            acc <= '0;
            last_win <= '0;
            emb_q <= '0;
        end
        else if (sample_valid)
        begin
            emb_q <= last_win | acc | next_hit;
            if (win_cnt >= win_last)
            begin
                win_cnt <= '0;
                last_win <= acc | next_hit;
                acc <= '0;
            end
            else
            begin
                win_cnt <= win_cnt + WIN_W'(1);
                acc <= acc | next_hit;
            end
        end
    end

    assign pin_flag = pin_q;
    assign embed_flag = emb_q;
    assign hit = hit_q;
endmodule

/* verilog/adc_overrange_detect.sv */
// Overrange detection, output coding and trim control with AXI4-Lite access
// ==================================================
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
module adc_overrange_detect
    import adc_ovr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sample_valid,
    input wire sample_pair_t sample_in,
    input wire logic cplx_valid,
    input wire iq_t cplx_a_in,
    input wire iq_t cplx_b_in,
    output logic chan_a_high_flag,
    output logic chan_a_low_flag,
    output logic chan_b_high_flag,
    output logic chan_b_low_flag,
    output logic cplx_out_valid,
    output iq_t cplx_a_out,
    output iq_t cplx_b_out,
    output logic dual_edge_sampling,
    output trim_set_t core_a_offset_trim,
    output trim_set_t core_b_offset_trim,
    output logic [TRIM_W-1:0] input_a_fullscale_trim,
    output logic [TRIM_W-1:0] input_b_fullscale_trim,
    output logic irq
);
    logic single_mode;
    logic decim_mode;
    logic fg_cal;
    logic [CMP_W-1:0] high_alarm_threshold;
    logic [CMP_W-1:0] low_alarm_threshold;
    logic [SET_W-1:0] alarm_stretch_setting;
    logic [TRIM_W-1:0] fs_trim_a;
    logic [TRIM_W-1:0] fs_trim_b;
    trim_set_t core_a_zero_phase_offset_trim;
    trim_set_t core_a_ninety_phase_offset_trim;
    trim_set_t core_b_zero_phase_offset_trim;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] irq_clear;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic aw_full;
    logic w_full;
    logic do_write;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    flag_pair_t pin_a;
    flag_pair_t pin_b;
    flag_pair_t emb_a;
    flag_pair_t emb_b;
    flag_pair_t hit_a;
    flag_pair_t hit_b;

    // Byte-lane merge of a write into a stored word
    function automatic logic [TRIM_W-1:0] merge(input logic [TRIM_W-1:0] old);
        logic [TRIM_W-1:0] res;
        res = old;
        for (int k = 0; k < TRIM_W / 8; k++)
        begin
            if (wr_strb[k])
                res[k*8 +: 8] = wr_data[k*8 +: 8];
        end
        return res;
    endfunction

    // ==================================================
    // AXI4-Lite write channel: address and data taken in either order
    assign do_write = aw_full && w_full && !s_axi_bvalid;

    assign wr_hit = (wr_addr <= REG_OB0_B) && (wr_addr[1:0] == 2'h0);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                wr_addr <= s_axi_awaddr;
                aw_full <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                w_full <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==================================================
    // Configuration registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            {fg_cal, decim_mode, single_mode} <= CTRL_RST;
            high_alarm_threshold <= HIGH_THR_RST;
            low_alarm_threshold <= LOW_THR_RST;
            alarm_stretch_setting <= STRETCH_RST;
            fs_trim_a <= FS_TRIM_RST;
            fs_trim_b <= FS_TRIM_RST;
            core_a_zero_phase_offset_trim <= {2{OFS_TRIM_RST}};
            core_a_ninety_phase_offset_trim <= {2{OFS_TRIM_RST}};
            core_b_zero_phase_offset_trim <= {2{OFS_TRIM_RST}};
        end
        else if (do_write)
        begin
            case (wr_addr)
                REG_CTRL:
                begin
                    if (wr_strb[0])
                    begin
                        single_mode <= wr_data[CTRL_SINGLE];
                        decim_mode <= wr_data[CTRL_DECIM];
                        fg_cal <= wr_data[CTRL_FGCAL];
                    end
                end
                REG_THRESH:
                begin
                    if (wr_strb[0])
                        high_alarm_threshold <= wr_data[THR_HIGH_LSB +: CMP_W];
                    if (wr_strb[1])
                        low_alarm_threshold <= wr_data[THR_LOW_LSB +: CMP_W];
                end
                REG_STRETCH:
                begin
                    if (wr_strb[0])
                        alarm_stretch_setting <= wr_data[SET_W-1:0];
                end
                REG_FS_A: fs_trim_a <= merge(fs_trim_a);
                REG_FS_B: fs_trim_b <= merge(fs_trim_b);
                REG_OA0_A: core_a_zero_phase_offset_trim.input_a <=
                    merge(core_a_zero_phase_offset_trim.input_a);
                REG_OA0_B: core_a_zero_phase_offset_trim.input_b <=
                    merge(core_a_zero_phase_offset_trim.input_b);
                REG_OA90_A: core_a_ninety_phase_offset_trim.input_a <=
                    merge(core_a_ninety_phase_offset_trim.input_a);
                REG_OA90_B: core_a_ninety_phase_offset_trim.input_b <=
                    merge(core_a_ninety_phase_offset_trim.input_b);
                REG_OB0_A: core_b_zero_phase_offset_trim.input_a <=
                    merge(core_b_zero_phase_offset_trim.input_a);
                REG_OB0_B: core_b_zero_phase_offset_trim.input_b <=
                    merge(core_b_zero_phase_offset_trim.input_b);
                default:
                begin
                end
            endcase
        end
    end

    // ==================================================
    // Interrupts: sticky events, write one to clear, set beats clear
    assign events = {hit_b.low, hit_b.high, hit_a.low, hit_a.high};
    assign irq_clear = (do_write && wr_addr == REG_IRQ_STATUS && wr_strb[0])
        ? wr_data[IRQ_W-1:0] : '0;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_status <= (irq_status & ~irq_clear) | events;
            if (do_write && wr_addr == REG_IRQ_MASK && wr_strb[0])
                irq_mask <= wr_data[IRQ_W-1:0];
            irq <= |(irq_status & irq_mask);
        end
    end

    // ==================================================
    // AXI4-Lite read channel, data one cycle after the address is taken
    always_comb
    begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            REG_CTRL: rd_word[CTRL_FGCAL:CTRL_SINGLE] = {fg_cal, decim_mode, single_mode};
            REG_THRESH: rd_word[THR_LOW_LSB+CMP_W-1:0] = {low_alarm_threshold,
                high_alarm_threshold};
            REG_STRETCH: rd_word[SET_W-1:0] = alarm_stretch_setting;
            REG_FLAGS: rd_word[IRQ_W-1:0] = {chan_b_low_flag, chan_b_high_flag,
                chan_a_low_flag, chan_a_high_flag};
            REG_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status;
            REG_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
            REG_FS_A: rd_word[TRIM_W-1:0] = fs_trim_a;
            REG_FS_B: rd_word[TRIM_W-1:0] = fs_trim_b;
            REG_OA0_A: rd_word[TRIM_W-1:0] = core_a_zero_phase_offset_trim.input_a;
            REG_OA0_B: rd_word[TRIM_W-1:0] = core_a_zero_phase_offset_trim.input_b;
            REG_OA90_A: rd_word[TRIM_W-1:0] = core_a_ninety_phase_offset_trim.input_a;
            REG_OA90_B: rd_word[TRIM_W-1:0] = core_a_ninety_phase_offset_trim.input_b;
            REG_OB0_A: rd_word[TRIM_W-1:0] = core_b_zero_phase_offset_trim.input_a;
            REG_OB0_B: rd_word[TRIM_W-1:0] = core_b_zero_phase_offset_trim.input_b;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==================================================
    // Overrange monitors: one per channel, shared thresholds
    // In single mode the A and B lanes carry the two interleaved cores
    overrange_monitor mon_a (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample_valid(sample_valid),
        .sample(sample_in.a),
        .high_thr(high_alarm_threshold),
        .low_thr(low_alarm_threshold),
        .stretch_setting(alarm_stretch_setting),
        .pin_flag(pin_a),
        .embed_flag(emb_a),
        .hit(hit_a)
    );

    overrange_monitor mon_b (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample_valid(sample_valid),
        .sample(sample_in.b),
        .high_thr(high_alarm_threshold),
        .low_thr(low_alarm_threshold),
        .stretch_setting(alarm_stretch_setting),
        .pin_flag(pin_b),
        .embed_flag(emb_b),
        .hit(hit_b)
    );

    // Monitor outputs are flops already; extra staging would add latency
    assign chan_a_high_flag = pin_a.high;
    assign chan_a_low_flag = pin_a.low;
    assign chan_b_high_flag = pin_b.high;
    assign chan_b_low_flag = pin_b.low;

    // ==================================================
    // Embedded status in complex samples
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cplx_out_valid <= 1'b0;
            cplx_a_out <= '0;
            cplx_b_out <= '0;
        end
        else
        begin
            cplx_out_valid <= cplx_valid;
            if (cplx_valid)
            begin
                cplx_a_out <= cplx_a_in;
                cplx_b_out <= cplx_b_in;
                if (decim_mode)
                begin
                    cplx_a_out.i <= {cplx_a_in.i[DATA_W-1:1], emb_a.high};
                    cplx_a_out.q <= {cplx_a_in.q[DATA_W-1:1], emb_a.low};
                    cplx_b_out.i <= {cplx_b_in.i[DATA_W-1:1], emb_b.high};
                    cplx_b_out.q <= {cplx_b_in.q[DATA_W-1:1], emb_b.low};
                end
            end
        end
    end

    // ==================================================
    // Sampling edge and trims to the analog side
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dual_edge_sampling <= 1'b0;
            core_a_offset_trim <= {2{OFS_TRIM_RST}};
            core_b_offset_trim <= {2{OFS_TRIM_RST}};
            input_a_fullscale_trim <= FS_TRIM_RST;
            input_b_fullscale_trim <= FS_TRIM_RST;
        end
        else
        begin
            dual_edge_sampling <= single_mode;
            input_a_fullscale_trim <= fs_trim_a;
            input_b_fullscale_trim <= fs_trim_b;
            // Background calibration owns offsets, so trims are parked at zero
            if (!fg_cal)
            begin
                core_a_offset_trim <= {2{OFS_TRIM_RST}};
                core_b_offset_trim <= {2{OFS_TRIM_RST}};
            end
            else
            begin
                core_a_offset_trim <= single_mode ? core_a_ninety_phase_offset_trim
                    : core_a_zero_phase_offset_trim;
                core_b_offset_trim <= core_b_zero_phase_offset_trim;
            end
        end
    end
endmodule

/* tb/ovr_monitor_sink.sv */
// Downstream monitor that merges same-index overrange outputs
module ovr_monitor_sink
(
    input wire logic a_high,
    input wire logic a_low,
    input wire logic b_high,
    input wire logic b_low,
    output logic any_high,
    output logic any_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================
    // Merge
    // In single mode each core reports its own half of the samples
    assign any_high = a_high | b_high;
    assign any_low = a_low | b_low;
endmodule

/* tb/adc_overrange_detect_props.sv */
// Port-level checker for the overrange block
module adc_overrange_detect_props
    import adc_ovr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire sample_pair_t sample_in,
    input wire logic cplx_valid,
    input wire iq_t cplx_a_in,
    input wire logic cplx_out_valid,
    input wire iq_t cplx_a_out,
    input wire logic chan_a_high_flag,
    input wire logic chan_a_low_flag,
    input wire logic chan_b_high_flag,
    input wire logic chan_b_low_flag,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==================================================
    // Properties
    a_neg_sat: assert property (
        sample_valid && sample_in.a == MOST_NEG_CODE |=> chan_a_high_flag && chan_a_low_flag)
        else $error("Saturated A sample not flagged");
    a_b_full: assert property (
        sample_valid && sample_in.b == 12'h7ff |=> chan_b_high_flag && chan_b_low_flag)
        else $error("Full-scale B sample not flagged");
    a_stretch_min: assert property ($rose(chan_a_high_flag) |=> chan_a_high_flag[*7])
        else $error("Flag shorter than eight cycles");
    a_cplx_next: assert property (cplx_valid |=> cplx_out_valid)
        else $error("Complex output valid missing");
    a_i_upper: assert property (
        cplx_valid |=> cplx_a_out.i[15:1] == $past(cplx_a_in.i[15:1]))
        else $error("I data bits altered");
    a_q_upper: assert property (
        cplx_valid |=> cplx_a_out.q[15:1] == $past(cplx_a_in.q[15:1]))
        else $error("Q data bits altered");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped early");
    a_read_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late");
endmodule
bind adc_overrange_detect adc_overrange_detect_props adc_overrange_detect_props_inst (.sys_clk,
    .rst_n, .sample_valid, .sample_in, .cplx_valid, .cplx_a_in, .cplx_out_valid, .cplx_a_out,
    .chan_a_high_flag, .chan_a_low_flag, .chan_b_high_flag, .chan_b_low_flag, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* tb/tb.sv */
// Self-checking bench for the overrange block
module tb
    import adc_ovr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = '0, rst_n = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, sample_valid = '0, cplx_valid = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, sticky = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cplx_out_valid, chan_a_high_flag, chan_a_low_flag, chan_b_high_flag, chan_b_low_flag;
    logic any_high, any_low;
    sample_pair_t sample_in = '0;
    iq_t cplx_a_in = '0, cplx_b_in = '0, cplx_a_out;
    logic [15:0] lf = 16'h005f, hs = '0;
    int error_cnt = 0, num_checks = 0, cyc = 0, cnt[4] = '{0, 0, 0, 0};
    adc_overrange_detect adc_overrange_detect_inst (.sys_clk, .rst_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid, .sample_in,
        .cplx_valid, .cplx_a_in, .cplx_b_in, .chan_a_high_flag, .chan_a_low_flag,
        .chan_b_high_flag, .chan_b_low_flag, .cplx_out_valid, .cplx_a_out, .cplx_b_out(),
        .dual_edge_sampling(), .core_a_offset_trim(), .core_b_offset_trim(),
        .input_a_fullscale_trim(), .input_b_fullscale_trim(), .irq);
    ovr_monitor_sink ovr_monitor_sink_inst (.a_high(chan_a_high_flag), .a_low(chan_a_low_flag),
        .b_high(chan_b_high_flag), .b_low(chan_b_low_flag), .any_high, .any_low);
    // ==================================================
    // Helpers
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Saturates so that the most negative code compares like full scale
    function automatic int mag8(input logic [11:0] x);
        int v;
        v = int'($signed(x));
        v = v < 0 ? -v : v;
        return (v > 2047 ? 2047 : v) >> 3;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end while (!s_axi_bvalid);
        s_axi_bready <= '0;
        chk(32'(s_axi_bresp), 32'(RESP_OKAY));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end while (!s_axi_rvalid);
        s_axi_rready <= '0;
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(r));
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==================================================
    // Main sequence
    initial
    begin
        logic [11:0] va, vb;
        logic [3:0] h, e;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'h1;
        rd(REG_THRESH, 32'h0000_40ff, RESP_OKAY);
        rd(REG_FS_A, 32'h0000_a000, RESP_OKAY);
        rd(8'h40, '0, RESP_SLVERR);
        wr(REG_THRESH, 32'h0000_40c0);
        wr(REG_CTRL, 32'h0000_0002);
        for (int i = 0; i < 400; i++)
        begin
            @(posedge sys_clk);
            lf = nx(lf);
            va = (i % 16 != 0) ? lf[11:0] : MOST_NEG_CODE;
            vb = (i % 16 == 8) ? 12'h7ff : lf[15:4];
            sample_valid <= 1'h1;
            sample_in <= {va, vb};
            cplx_valid <= lf[0];
            cplx_a_in <= {lf, ~lf};
            #1;
            e = {cnt[3] != 0, cnt[2] != 0, cnt[1] != 0, cnt[0] != 0};
            chk({chan_b_low_flag, chan_b_high_flag, chan_a_low_flag, chan_a_high_flag}, e);
            chk({any_low, any_high}, {e[3] | e[1], e[2] | e[0]});
            if (cplx_out_valid)
                chk({cplx_a_out.i[0], cplx_a_out.q[0]}, {hs[4] | hs[8], hs[5] | hs[9]});
            h = {mag8(vb) >= 'h40, mag8(vb) >= 'hc0, mag8(va) >= 'h40, mag8(va) >= 'hc0};
            for (int k = 0; k < 4; k++) cnt[k] = h[k] ? 8 : (cnt[k] > 0 ? cnt[k] - 1 : 0);
            sticky = sticky | h;
            hs = {hs[11:0], h};
        end
        @(posedge sys_clk);
        sample_valid <= '0;
        repeat (20) @(posedge sys_clk);
        rd(REG_FLAGS, '0, RESP_OKAY);
        rd(REG_IRQ_STATUS, {28'h0, sticky}, RESP_OKAY);
        chk(32'(irq), '0);
        wr(REG_IRQ_MASK, 32'h0000_000f);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'(|sticky));
        wr(REG_IRQ_STATUS, 32'h0000_000f);
        rd(REG_IRQ_STATUS, '0, RESP_OKAY);
        chk(32'(irq), '0);
        // One isolated hit per setting: length is the bare stretch
        for (int n = 0; n < 8; n++)
        begin
            wr(REG_STRETCH, 32'(n));
            @(posedge sys_clk);
            sample_in <= {MOST_NEG_CODE, 12'h000};
            sample_valid <= 1'h1;
            cnt[0] = 0;
            repeat (1100)
            begin
                @(posedge sys_clk);
                sample_valid <= '0;
                #1;
                cnt[0] += int'(any_high);
            end
            chk(32'(cnt[0]), 32'(8 << n));
        end
        tally_and_finish();
    end
endmodule
